// ---- logic/pmrtp_phy_end.sv ----
// Purpose: PHY end: drives the link clock, captures MAC transmit data, encodes it, drives the interrupt pin.
// Assumes: Straps stable during reset; config inputs are on clk.
// Notes: RMII reference clock is made here at the nibble clock rate.
`timescale 1ns/1ps
// Operation
// - MAC uses two lowest data lines in RMII.
// - MAC grounds data bits two, three in RMII.
// - Enable marks valid four-bit data in MII.
// - RMII takes only two lowest bits.
// - MII clock driven: 25 or 2.5 MHz.
// - RMII ignores error, top bit, clock.
// - Error substitutes halt code-group for data.
// - Error input ignored at 10 Mbps.
// - EEE: error line means LPI when idle.
// - Symbol mode: top bit is code MSB.
// - Active-low open-drain interrupt, pulled up.
// - Interrupt routable to either status light.
// - Wake events raise the interrupt.
// - Straps configure without any register access.
// - Software writes reserved bits as zero.
// - Strap low selects MII, high RMII.
module pmrtp_phy_end (
   input wire logic clk,
   input wire logic rst,
   pmrtp_if.phy link,
   input wire logic reducedIfaceSelectStrap,
   input wire logic irqPinSelectStrap,
   input wire logic speed100,
   input wire logic eeeEnable,
   input wire logic symbolMode,
   input wire logic [1:0] irqRoute,
   input wire logic [pmrtp_pkg::LIGHT_N-1:0] lightOn,
   input wire logic [pmrtp_pkg::WOL_W-1:0] wolEvent,
   input wire logic irqClear,
   output logic [pmrtp_pkg::SYM_W-1:0] capCode_q,
   output logic capValid_q,
   output logic capErr_q,
   output logic lpiActive_q,
   output logic rmiiActive_q,
   output logic irqPending_q
);
   // ==================================================
   // Strap capture at reset release
   logic [1:0] strapSync1_q;
   logic [1:0] strapSync2_q;
   logic strapDone_q;
   logic irqSelStrap_q;

   always_ff @(posedge clk) begin
      strapSync1_q <= {irqPinSelectStrap, reducedIfaceSelectStrap};
      strapSync2_q <= strapSync1_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         strapDone_q <= 1'b0;
         rmiiActive_q <= 1'b0;
         irqSelStrap_q <= 1'b1;
      end else if (!strapDone_q) begin
         strapDone_q <= 1'b1;
         rmiiActive_q <= strapSync2_q[0];
         irqSelStrap_q <= strapSync2_q[1];
      end
   end

   // ==================================================
   // Link clock divider
   logic [pmrtp_pkg::DIV_W-1:0] divCnt_q;
   logic [pmrtp_pkg::DIV_W-1:0] divCnt_d;
   logic linkClk_q;
   logic linkClk_d;
   logic riseTick_q;
   logic txClkPin_q;
   logic refClkPin_q;
   wire [pmrtp_pkg::DIV_W-1:0] halfLast = speed100 ? pmrtp_pkg::FAST_LAST : pmrtp_pkg::SLOW_LAST;
   wire wrap = divCnt_q >= halfLast;

   assign divCnt_d = wrap ? '0 : pmrtp_pkg::DIV_W'(divCnt_q + 1'b1);
   assign linkClk_d = wrap ? !linkClk_q : linkClk_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         divCnt_q <= '0;
         linkClk_q <= 1'b0;
         riseTick_q <= 1'b0;
         txClkPin_q <= 1'b0;
         refClkPin_q <= 1'b0;
      end else begin
         divCnt_q <= divCnt_d;
         linkClk_q <= linkClk_d;
         riseTick_q <= wrap & !linkClk_q;
         txClkPin_q <= linkClk_d & !rmiiActive_q;
         refClkPin_q <= linkClk_d & rmiiActive_q;
      end
   end

   assign link.txClk = txClkPin_q;
   assign link.refClk = refClkPin_q;

   // ==================================================
   // Pin synchroniser and delayed sample point
   pmrtp_pkg::pmrtp_pins_t pinSync1_q;
   pmrtp_pkg::pmrtp_pins_t pinSync2_q;
   logic [pmrtp_pkg::SAMPLE_LAG-1:0] lag_q;

   always_ff @(posedge clk) begin
      pinSync1_q <= {link.txSymbolTopBit, link.txEr, link.txEn, link.txd};
      pinSync2_q <= pinSync1_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lag_q <= '0;
      end else begin
         lag_q <= {lag_q[pmrtp_pkg::SAMPLE_LAG-2:0], riseTick_q};
      end
   end

   // Data seen at the sample point is what the MAC launched for the preceding falling edge
   wire sampleNow = lag_q[pmrtp_pkg::SAMPLE_LAG-1];

   // ==================================================
   // Capture, pairing and encoding
   logic rmiiHalf_q;
   logic [pmrtp_pkg::DIBIT_W-1:0] rmiiLow_q;
   wire [pmrtp_pkg::DIBIT_W-1:0] dibit = pinSync2_q.txd[pmrtp_pkg::DIBIT_W-1:0];
   wire nibbleReady = sampleNow & pinSync2_q.en & (!rmiiActive_q | rmiiHalf_q);
   wire [pmrtp_pkg::TXD_W-1:0] nibble = rmiiActive_q ? {dibit, rmiiLow_q} : pinSync2_q.txd;
   wire miiFast = !rmiiActive_q & speed100;
   wire errUsed = miiFast & pinSync2_q.er;
   wire symUsed = miiFast & symbolMode;
   wire [pmrtp_pkg::SYM_W-1:0] symCode = {pinSync2_q.topBit, nibble};
   wire [pmrtp_pkg::SYM_W-1:0] slowCode = {1'b0, nibble};
   wire [pmrtp_pkg::SYM_W-1:0] dataCode = errUsed ? pmrtp_pkg::CODE_HALT : pmrtp_pkg::pmrtp_encode(nibble);
   // 100 Mbps runs through the encoder in both pin modes, except MII symbol mode, which passes the raw code
   wire [pmrtp_pkg::SYM_W-1:0] code = symUsed ? symCode : (speed100 ? dataCode : slowCode);
   wire lpiNow = eeeEnable & miiFast & !pinSync2_q.en & pinSync2_q.er;

   always_ff @(posedge clk) begin
      if (rst) begin
         rmiiHalf_q <= 1'b0;
         rmiiLow_q <= '0;
      end else if (sampleNow) begin
         rmiiHalf_q <= rmiiActive_q & pinSync2_q.en & !rmiiHalf_q;
         rmiiLow_q <= dibit;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         capCode_q <= '0;
         capValid_q <= 1'b0;
         capErr_q <= 1'b0;
         lpiActive_q <= 1'b0;
      end else begin
         capValid_q <= nibbleReady;
         capErr_q <= nibbleReady & errUsed & !symUsed;
         if (nibbleReady) begin
            capCode_q <= code;
         end
         if (sampleNow) begin
            lpiActive_q <= lpiNow;
         end
      end
   end

   // ==================================================
   // Interrupt and pin routing
   logic irqOut_q;
   logic irqOe_q;
   logic [pmrtp_pkg::LIGHT_N-1:0] lightOut_q;
   logic [pmrtp_pkg::LIGHT_N-1:0] lightOe_q;
   wire [pmrtp_pkg::LIGHT_N-1:0] routeLight = {irqRoute == pmrtp_pkg::IRQ_ROUTE_LIGHT_TWO,
                                               irqRoute == pmrtp_pkg::IRQ_ROUTE_LIGHT_ONE};
   wire irqOnDefault = irqSelStrap_q & !(|routeLight);

   always_ff @(posedge clk) begin
      if (rst) begin
         irqPending_q <= 1'b0;
      end else begin
         // A new wake event wins over a clear in the same cycle
         irqPending_q <= (|wolEvent) | (irqPending_q & !irqClear);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irqOut_q <= 1'b1;
         irqOe_q <= 1'b1;
      end else begin
         irqOut_q <= !(irqPending_q & irqOnDefault);
         irqOe_q <= !(irqPending_q & irqOnDefault);
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < pmrtp_pkg::LIGHT_N; gi++) begin : gLight
         always_ff @(posedge clk) begin
            if (rst) begin
               lightOut_q[gi] <= 1'b0;
               lightOe_q[gi] <= 1'b1;
            end else if (routeLight[gi]) begin
               lightOut_q[gi] <= 1'b0;
               lightOe_q[gi] <= !irqPending_q;
            end else begin
               lightOut_q[gi] <= lightOn[gi];
               lightOe_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign link.irqOut_n = irqOut_q;
   assign link.irqOe_n = irqOe_q;
   assign link.statusLightOut = lightOut_q;
   assign link.statusLightOe_n = lightOe_q;
endmodule : pmrtp_phy_end

// ---- logic/pmrtp_pkg.sv ----
// Purpose: Shared constants, types and code table for the MII/RMII transmit port.
// Assumes: System clock of 100 MHz on both ends.
// Notes: Link clock periods are derived from the rates below.
package pmrtp_pkg;
   // ==================================================
   // Timing
   localparam int CLK_KHZ = 100000;
   localparam int MII_FAST_KHZ = 25000;
   localparam int MII_SLOW_KHZ = 2500;
   localparam int DIV_W = 5;
   localparam int FAST_HALF = CLK_KHZ / (2 * MII_FAST_KHZ);
   localparam int SLOW_HALF = CLK_KHZ / (2 * MII_SLOW_KHZ);
   localparam logic [DIV_W-1:0] FAST_LAST = DIV_W'(FAST_HALF - 1);
   localparam logic [DIV_W-1:0] SLOW_LAST = DIV_W'(SLOW_HALF - 1);
   // Rising edge to capture: covers MAC launch plus two synchroniser stages
   localparam int SAMPLE_LAG = 2 * FAST_HALF;

   // ==================================================
   // Widths and codes
   localparam int TXD_W = 4;
   localparam int SYM_W = 5;
   localparam int DIBIT_W = 2;
   localparam int WOL_W = 4;
   localparam int LIGHT_N = 2;
   localparam int LINK_TX = 0;
   localparam int LINK_REF = 1;
   localparam logic [SYM_W-1:0] CODE_HALT = 5'h04;
   localparam logic [1:0] IRQ_ROUTE_DEFAULT = 2'h0;
   localparam logic [1:0] IRQ_ROUTE_LIGHT_ONE = 2'h1;
   localparam logic [1:0] IRQ_ROUTE_LIGHT_TWO = 2'h2;

   // ==================================================
   // Types
   typedef struct packed {
      logic topBit;
      logic er;
      logic en;
      logic [TXD_W-1:0] txd;
   } pmrtp_pins_t;

   typedef enum logic [1:0] {
      MAC_IDLE = 2'h0,
      MAC_NIB = 2'h1,
      MAC_HIGH = 2'h3
   } pmrtp_mac_state_t;

   // ==================================================
   // 4B/5B data code-groups
   function automatic logic [SYM_W-1:0] pmrtp_encode(input logic [TXD_W-1:0] nib);
      logic [SYM_W-1:0] code;
      code = 5'h1E;
      unique case (nib)
         4'h0: code = 5'h1E;
         4'h1: code = 5'h09;
         4'h2: code = 5'h14;
         4'h3: code = 5'h15;
         4'h4: code = 5'h0A;
         4'h5: code = 5'h0B;
         4'h6: code = 5'h0E;
         4'h7: code = 5'h0F;
         4'h8: code = 5'h12;
         4'h9: code = 5'h13;
         4'hA: code = 5'h16;
         4'hB: code = 5'h17;
         4'hC: code = 5'h1A;
         4'hD: code = 5'h1B;
         4'hE: code = 5'h1C;
         4'hF: code = 5'h1D;
      endcase
      return code;
   endfunction : pmrtp_encode
endpackage : pmrtp_pkg

// ---- logic/pmrtp_if.sv ----
// Purpose: Pin bundle between the PHY transmit port and the MAC.
// Assumes: Open-drain pins idle high through pull-ups.
// Notes: Output enables are active low.
`timescale 1ns/1ps
interface pmrtp_if;
   logic txClk;
   logic refClk;
   logic [pmrtp_pkg::TXD_W-1:0] txd;
   logic txEn;
   logic txEr;
   logic txSymbolTopBit;
   logic irqOut_n;
   logic irqOe_n;
   logic irqLine_n;
   logic [pmrtp_pkg::LIGHT_N-1:0] statusLightOut;
   logic [pmrtp_pkg::LIGHT_N-1:0] statusLightOe_n;
   logic [pmrtp_pkg::LIGHT_N-1:0] statusLightLine;

   // ==================================================
   // Wire levels with pull-ups
   assign irqLine_n = irqOe_n ? 1'b1 : irqOut_n;
   genvar gi;
   generate
      for (gi = 0; gi < pmrtp_pkg::LIGHT_N; gi++) begin : gLight
         assign statusLightLine[gi] = statusLightOe_n[gi] ? 1'b1 : statusLightOut[gi];
      end
   endgenerate

   modport phy (
      input txd,
      input txEn,
      input txEr,
      input txSymbolTopBit,
      output txClk,
      output refClk,
      output irqOut_n,
      output irqOe_n,
      output statusLightOut,
      output statusLightOe_n
   );
   modport mac (
      output txd,
      output txEn,
      output txEr,
      output txSymbolTopBit,
      input txClk,
      input refClk,
      input irqLine_n
   );
endinterface : pmrtp_if

// ---- logic/pmrtp_mac_end.sv ----
// Purpose: MAC end: launches transmit nibbles or dibits on falling link clock edges.
// Assumes: User side on clk; link clock made by the PHY.
// Notes: A word is taken at the falling edge that starts it.
`timescale 1ns/1ps
module pmrtp_mac_end (
   input wire logic clk,
   input wire logic rst,
   pmrtp_if.mac link,
   input wire logic rmiiMode,
   input wire logic sendValid,
   input wire logic [pmrtp_pkg::TXD_W-1:0] sendNibble,
   input wire logic sendTopBit,
   input wire logic sendErr,
   input wire logic lpiRequest,
   output logic sendTaken_q,
   output logic irqSeen_q
);
   // ==================================================
   // Clock and interrupt synchronisers
   logic [1:0] clkSync1_q;
   logic [1:0] clkSync2_q;
   logic [1:0] clkSync3_q;
   logic irqSync1_q;
   logic irqSync2_q;

   always_ff @(posedge clk) begin
      clkSync1_q <= {link.refClk, link.txClk};
      clkSync2_q <= clkSync1_q;
      clkSync3_q <= clkSync2_q;
      irqSync1_q <= link.irqLine_n;
      irqSync2_q <= irqSync1_q;
   end

   wire [1:0] fallVec = clkSync3_q & ~clkSync2_q;
   wire fall = rmiiMode ? fallVec[pmrtp_pkg::LINK_REF] : fallVec[pmrtp_pkg::LINK_TX];

   // ==================================================
   // Launch selection
   pmrtp_pkg::pmrtp_mac_state_t state_q;
   pmrtp_pkg::pmrtp_mac_state_t state_d;
   logic [pmrtp_pkg::TXD_W-1:0] held_q;
   logic [pmrtp_pkg::TXD_W-1:0] txd_q;
   logic en_q;
   logic er_q;
   logic top_q;
   wire sendHigh = fall & rmiiMode & (state_q == pmrtp_pkg::MAC_NIB);
   wire startWord = fall & sendValid & !sendHigh;
   wire [pmrtp_pkg::TXD_W-1:0] lowDibit = {{(pmrtp_pkg::TXD_W-pmrtp_pkg::DIBIT_W){1'b0}},
                                           sendNibble[pmrtp_pkg::DIBIT_W-1:0]};
   wire [pmrtp_pkg::TXD_W-1:0] highDibit = {{(pmrtp_pkg::TXD_W-pmrtp_pkg::DIBIT_W){1'b0}},
                                            held_q[pmrtp_pkg::TXD_W-1 -: pmrtp_pkg::DIBIT_W]};
   wire [pmrtp_pkg::TXD_W-1:0] startTxd = rmiiMode ? lowDibit : sendNibble;
   wire [pmrtp_pkg::TXD_W-1:0] txd_d = sendHigh ? highDibit : (startWord ? startTxd : '0);
   wire er_d = !rmiiMode & (startWord ? sendErr : (!sendHigh & lpiRequest));
   wire top_d = !rmiiMode & startWord & sendTopBit;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         pmrtp_pkg::MAC_IDLE: state_d = startWord ? pmrtp_pkg::MAC_NIB : pmrtp_pkg::MAC_IDLE;
         pmrtp_pkg::MAC_NIB: begin
            if (sendHigh) begin
               state_d = pmrtp_pkg::MAC_HIGH;
            end else if (fall) begin
               state_d = startWord ? pmrtp_pkg::MAC_NIB : pmrtp_pkg::MAC_IDLE;
            end
         end
         pmrtp_pkg::MAC_HIGH: begin
            if (fall) begin
               state_d = startWord ? pmrtp_pkg::MAC_NIB : pmrtp_pkg::MAC_IDLE;
            end
         end
         default: state_d = pmrtp_pkg::MAC_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= pmrtp_pkg::MAC_IDLE;
         held_q <= '0;
         txd_q <= '0;
         en_q <= 1'b0;
         er_q <= 1'b0;
         top_q <= 1'b0;
      end else if (fall) begin
         state_q <= state_d;
         held_q <= startWord ? sendNibble : held_q;
         txd_q <= txd_d;
         en_q <= startWord | sendHigh;
         er_q <= er_d;
         top_q <= top_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sendTaken_q <= 1'b0;
         irqSeen_q <= 1'b0;
      end else begin
         sendTaken_q <= startWord;
         irqSeen_q <= !irqSync2_q;
      end
   end

   assign link.txd = txd_q;
   assign link.txEn = en_q;
   assign link.txEr = er_q;
   assign link.txSymbolTopBit = top_q;
endmodule : pmrtp_mac_end

// ---- bench/pmrtp_assertions.sv ----
// Purpose: Link-level checks for the PHY and MAC ends of the transmit port.
// Assumes: Both ends share clk and rst; link clock is txClk or refClk.
// Notes: Helper counters measure link clock half periods.
`timescale 1ns/1ps
module pmrtp_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic txClk,
   input wire logic refClk,
   input wire logic [pmrtp_pkg::TXD_W-1:0] txd,
   input wire logic txEn,
   input wire logic txEr,
   input wire logic txSymbolTopBit,
   input wire logic irqOut_n,
   input wire logic irqOe_n,
   input wire logic irqLine_n
);
   // ==================================================
   // Helpers
   logic [4:0] hiCnt_q;
   logic [4:0] loCnt_q;
   logic [3:0] fallDly_q;
   logic started_q;
   logic rmiiSeen_q;
   logic linkClk_q;
   wire linkClk = txClk | refClk;
   wire linkFall = linkClk_q & ~linkClk;

   always_ff @(posedge clk) begin
      if (rst) begin
         hiCnt_q <= 5'h00;
         loCnt_q <= 5'h00;
         fallDly_q <= 4'h0;
         started_q <= 1'b0;
         rmiiSeen_q <= 1'b0;
         linkClk_q <= 1'b0;
      end else begin
         hiCnt_q <= linkClk ? hiCnt_q + 5'h01 : 5'h00;
         loCnt_q <= linkClk ? 5'h00 : loCnt_q + 5'h01;
         fallDly_q <= {fallDly_q[2:0], linkFall};
         started_q <= started_q | linkFall;
         rmiiSeen_q <= rmiiSeen_q | refClk;
         linkClk_q <= linkClk;
      end
   end

   // ==================================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   clk_high_a: assert property (linkFall |-> hiCnt_q == 5'h02 || hiCnt_q == 5'h14)
      else $error("link clock high time wrong");
   clk_low_a: assert property ($rose(linkClk) && started_q |-> loCnt_q == 5'h02 || loCnt_q == 5'h14)
      else $error("link clock low time wrong");
   clk_idle_a: assert property ($fell(rst) |-> !linkClk)
      else $error("link clock high at reset release");
   clk_excl_a: assert property (!(txClk && refClk))
      else $error("both link clocks high");
   rmii_ground_a: assert property (rmiiSeen_q |-> txd[3:2] == 2'h0 && !txEr && !txSymbolTopBit)
      else $error("unused lines driven in reduced mode");
   launch_fall_a: assert property ($changed({txd, txEn, txEr, txSymbolTopBit}) |-> |fallDly_q[3:1])
      else $error("transmit lines changed away from a falling link edge");
   irq_pair_a: assert property (irqOe_n == irqOut_n)
      else $error("interrupt pin drives high or enable mismatched");
   irq_idle_a: assert property ($fell(rst) |-> irqLine_n[*2])
      else $error("interrupt line low after reset");
endmodule : pmrtp_assertions

// ---- bench/pmrtp_tb.sv ----
// Purpose: Self-checking bench joining the PHY and MAC ends of the transmit port.
// Assumes: Straps change only during reset or just before it is asserted.
// Notes: Captured code groups are queued and compared in order.
`timescale 1ns/1ps
module pmrtp_tb;
   logic clk, rst, rmiiStrap, irqStrap, spd, eee, sym;
   logic [1:0] irqRoute, lightOn;
   logic [3:0] wolEvent, sendNibble;
   logic irqClear, sendValid, sendTopBit, sendErr, lpiRequest;
   logic [4:0] capCode;
   logic capValid, capErr, lpiActive, rmiiActive, irqPending, sendTaken, irqSeen;
   logic [5:0] capQ [$];
   int n_errors, n_tests, i;
   // Flags rmii spd sym err top, nibble, expected {err, code}
   localparam logic [14:0] ROWS [8] = '{
      {5'h08, 4'h5, 6'h0B}, {5'h0A, 4'h5, 6'h24}, {5'h02, 4'hA, 6'h0A}, {5'h0D, 4'h3, 6'h13},
      {5'h1B, 4'hE, 6'h1C}, {5'h10, 4'h9, 6'h09}, {5'h08, 4'h0, 6'h1E}, {5'h05, 4'h7, 6'h07}};

   pmrtp_if link();
   pmrtp_phy_end u_pmrtp_phy_end (.clk(clk), .rst(rst), .link(link), .reducedIfaceSelectStrap(rmiiStrap),
      .irqPinSelectStrap(irqStrap), .speed100(spd), .eeeEnable(eee), .symbolMode(sym), .irqRoute(irqRoute),
      .lightOn(lightOn), .wolEvent(wolEvent), .irqClear(irqClear), .capCode_q(capCode), .capValid_q(capValid),
      .capErr_q(capErr), .lpiActive_q(lpiActive), .rmiiActive_q(rmiiActive), .irqPending_q(irqPending));
   pmrtp_mac_end u_pmrtp_mac_end (.clk(clk), .rst(rst), .link(link), .rmiiMode(rmiiStrap),
      .sendValid(sendValid), .sendNibble(sendNibble), .sendTopBit(sendTopBit), .sendErr(sendErr),
      .lpiRequest(lpiRequest), .sendTaken_q(sendTaken), .irqSeen_q(irqSeen));
   pmrtp_assertions u_pmrtp_assertions (.clk(clk), .rst(rst), .txClk(link.txClk), .refClk(link.refClk),
      .txd(link.txd), .txEn(link.txEn), .txEr(link.txEr), .txSymbolTopBit(link.txSymbolTopBit),
      .irqOut_n(link.irqOut_n), .irqOe_n(link.irqOe_n), .irqLine_n(link.irqLine_n));

   // ==================================================
   // Tasks
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic results();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   task automatic reset_to(input logic [4:0] f);
      @(negedge clk);
      rst = 1'b1;
      {rmiiStrap, spd, sym, sendErr, sendTopBit} = f;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      capQ.delete();
      @(negedge clk);
      check("rmiiActive", 8'(rmiiActive), 8'(f[4]));
   endtask : reset_to

   task automatic send(input logic [3:0] nib, input logic last);
      int n;
      sendNibble = nib;
      sendValid = 1'b1;
      @(negedge clk);
      for (n = 0; n < 200 && sendTaken !== 1'b1; n++) @(negedge clk);
      check("sendTaken", 8'(sendTaken), 8'h01);
      if (last) sendValid = 1'b0;
   endtask : send

   task automatic expect_cap(input logic [5:0] exp);
      int n;
      for (n = 0; n < 300 && capQ.size() == 0; n++) @(negedge clk);
      check("capture", (capQ.size() > 0) ? 8'(capQ.pop_front()) : 8'hFF, 8'(exp));
   endtask : expect_cap

   always @(posedge clk) if (capValid === 1'b1) capQ.push_back({capErr, capCode});

   // ==================================================
   // Stimulus
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      #200000;
      n_errors++;
      results();
   end

   initial begin
      {rst, rmiiStrap, irqStrap, spd, eee, sym, irqClear, sendValid, sendTopBit, sendErr, lpiRequest} = 11'h500;
      {irqRoute, lightOn, wolEvent, sendNibble} = 12'h300;
      n_errors = 0;
      n_tests = 0;
      for (i = 0; i < 8; i++) begin
         reset_to(ROWS[i][14:10]);
         send(ROWS[i][9:6], 1'b1);
         expect_cap(ROWS[i][5:0]);
      end
      reset_to(5'h08);
      send(4'h0, 1'b0);
      send(4'hF, 1'b1);
      expect_cap(6'h1E);
      expect_cap(6'h1D);
      reset_to(5'h18);
      send(4'h6, 1'b0);
      send(4'h1, 1'b1);
      expect_cap(6'h0E);
      expect_cap(6'h09);
      reset_to(5'h08);
      eee = 1'b1;
      lpiRequest = 1'b1;
      repeat (20) @(negedge clk);
      check("lpiActive", 8'(lpiActive), 8'h01);
      lpiRequest = 1'b0;
      repeat (20) @(negedge clk);
      check("lpiActive", 8'(lpiActive), 8'h00);
      check("idleCaptures", 8'(capQ.size()), 8'h00);
      eee = 1'b0;
      for (i = 0; i < 7; i++) begin
         irqRoute = (i > 3) ? 2'(i - 3) : 2'h0;
         wolEvent = 4'h1 << (i % 4);
         @(negedge clk);
         wolEvent = 4'h0;
         repeat (4) @(negedge clk);
         check("irqSet", {3'h0, irqPending, irqSeen, link.irqLine_n, link.statusLightLine},
            {4'h1, irqRoute[1] == irqRoute[0], irqRoute[1] != irqRoute[0], irqRoute != 2'h2,
             irqRoute != 2'h1});
         irqClear = 1'b1;
         @(negedge clk);
         irqClear = 1'b0;
         @(negedge clk);
         check("irqClr", {4'h0, irqPending, link.irqLine_n, link.statusLightLine}, 8'h07);
      end
      irqRoute = 2'h0;
      irqStrap = 1'b0;
      reset_to(5'h08);
      wolEvent = 4'h4;
      @(negedge clk);
      wolEvent = 4'h0;
      repeat (3) @(negedge clk);
      check("irqStrapOff", {6'h00, irqPending, link.irqLine_n}, 8'h03);
      results();
   end
endmodule : pmrtp_tb
